// file: src/dtc_defines.svh
// dtc_defines.svh: offsets, field positions and reset values of the
// dram timing configuration block.
// assumes: included by its bare name from every file that needs it.
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH

// byte offsets on the register port
`define DTC_OFS_CFG_LO    8'h00
`define DTC_OFS_CFG_HI    8'h01
`define DTC_OFS_STATUS    8'h02

// configuration word reset value, slowest timing
`define DTC_CFG_RESET     16'hFFFF

// configuration field positions
`define DTC_BIT_FPM       15
`define DTC_BIT_DUAL      14
`define DTC_BIT_DEPTH_HI  13
`define DTC_BIT_DEPTH_LO  12
`define DTC_BIT_UNUSED    11
`define DTC_BIT_ADS_DLY   10
`define DTC_BIT_RFSH_W    9
`define DTC_BIT_PRECHG    8
`define DTC_BIT_WDD_HI    7
`define DTC_BIT_WAD_HI    5
`define DTC_BIT_WAD_LO    4
`define DTC_BIT_RDD_HI    3
`define DTC_BIT_RDD_LO    2
`define DTC_BIT_RAD_HI    1
`define DTC_BIT_RAD_LO    0

// cycle counts chosen by single configuration bits
`define DTC_RFSH_SHORT    2'h2
`define DTC_RFSH_LONG     2'h3
`define DTC_PRECHG_SHORT  2'h1
`define DTC_PRECHG_LONG   2'h2

// processor address bits 31:30 that select dram
`define DTC_DRAM_REGION   2'h0

`endif

// file: src/dtc_pkg.sv
// dtc_pkg.sv: types shared by the dram timing configuration block.
// assumes: compiled before every module of the block.
package dtc_pkg;

	// bank depth selection
	typedef enum logic [1:0] {
		DTC_D256K = 2'h0,
		DTC_D1M   = 2'h1,
		DTC_D4M   = 2'h2
	} dtc_depth_e;

	// access sequencer states
	typedef enum logic [2:0] {
		DTC_IDLE     = 3'h0,
		DTC_RFSH     = 3'h1,
		DTC_ADDR_WT  = 3'h2,
		DTC_DATA     = 3'h3,
		DTC_DATA_WT  = 3'h4,
		DTC_PRECHG   = 3'h5
	} dtc_state_e;

endpackage : dtc_pkg

// file: src/dtc_cfg_reg.sv
// dtc_cfg_reg.sv: the 16-bit configuration word as two byte lanes.
// assumes: byte writes come from the main block's address decode.
`timescale 1ns/1ps
`include "dtc_defines.svh"

module dtc_cfg_reg import dtc_pkg::*; (
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic [1:0]  byte_wr,
	input  wire logic [7:0]  wdata,
	output logic      [15:0] cfg
);

	localparam logic [15:0] CFG_RST = `DTC_CFG_RESET;

	// one lane per byte, written separately or back to back
	for (genvar b = 0; b < 2; b++) begin : g_lane
		logic [7:0] lane_q;
		always_ff @(posedge mclk) begin
			if (sys_rst) begin
				lane_q <= CFG_RST[8*b +: 8];
			end else if (byte_wr[b]) begin
				lane_q <= wdata;
			end
		end
		assign cfg[8*b +: 8] = lane_q;
	end

endmodule : dtc_cfg_reg

// file: src/dtc_field_decode.sv
// dtc_field_decode.sv: turns the configuration word into timing fields.
// assumes: the word is sampled by the sequencer at each access start.
`timescale 1ns/1ps
`include "dtc_defines.svh"

module dtc_field_decode import dtc_pkg::*; (
	input  wire logic [15:0] cfg,
	output logic             fpm_mode,
	output logic             dual_bank,
	output dtc_depth_e       depth,
	output logic             ads_delay,
	output logic      [1:0]  rfsh_cycles,
	output logic      [1:0]  prechg_cycles,
	output logic      [1:0]  wr_addr_wait,
	output logic      [1:0]  wr_data_wait,
	output logic      [1:0]  rd_addr_wait,
	output logic      [1:0]  rd_data_wait
);

	// 0x -> 1, 10 -> 2, 11 -> 3; shared by read and write address waits
	function automatic logic [1:0] addr_waits(input logic [1:0] f);
		addr_waits = f[1] ? {1'b1, f[0]} : 2'h1;
	endfunction : addr_waits

	// bit 11 is deliberately left out of every field
	assign fpm_mode      = cfg[`DTC_BIT_FPM];
	assign dual_bank     = cfg[`DTC_BIT_DUAL];
	assign depth         = cfg[`DTC_BIT_DEPTH_HI] ? DTC_D4M :
	                       (cfg[`DTC_BIT_DEPTH_LO] ? DTC_D1M : DTC_D256K);
	assign ads_delay     = cfg[`DTC_BIT_ADS_DLY];
	assign rfsh_cycles   = cfg[`DTC_BIT_RFSH_W] ?
	                       `DTC_RFSH_LONG : `DTC_RFSH_SHORT;
	assign prechg_cycles = cfg[`DTC_BIT_PRECHG] ?
	                       `DTC_PRECHG_LONG : `DTC_PRECHG_SHORT;
	// write: bit 6 ignored, bit 7 picks 1 or 2 data waits
	assign wr_addr_wait  = addr_waits(cfg[`DTC_BIT_WAD_HI:`DTC_BIT_WAD_LO]);
	assign wr_data_wait  = cfg[`DTC_BIT_WDD_HI] ? 2'h2 : 2'h1;
	// read: 00 -> 0, 01 -> 1, 1x -> 2 data waits
	assign rd_addr_wait  = addr_waits(cfg[`DTC_BIT_RAD_HI:`DTC_BIT_RAD_LO]);
	assign rd_data_wait  = cfg[`DTC_BIT_RDD_HI] ? 2'h2 :
	                       {1'b0, cfg[`DTC_BIT_RDD_LO]};

endmodule : dtc_field_decode

// file: src/dtc_dram_timing.sv
// dtc_dram_timing.sv: dram timing configuration register and the
// access sequencer that obeys it.
// assumes: one 50 MHz clock; processor pins synchronous to it; the
// register port strobes last one cycle and never overlap.
//
// What this block does
// - bit 15 set gives fast-page-mode cas timing, clear gives edo timing.
// - bit 14 set decodes two banks per module (four), clear one (two).
// - bits 13:12 pick 256K, 1M or 4M words and the row/column split.
// - at 256K depth each bank is 256K by 32 with nine address lines.
// - bit 11 changes nothing in the controller.
// - bit 10 set uses the address strobe one clock late, clear at once.
// - refresh holds ras for two clocks, or three with bit 9 set.
// - ras stays off at least one clock, or two with bit 8 set, between uses.
// - write waits are 1/2/3 from bits 5:4 then 1 or 2 per bit 7.
// - read waits are 1/2/3 from bits 1:0 then 0/1/2 from bits 3:2.
// - every reset loads the configuration word with all ones.
// - the word is accessed as low and high bytes, also back to back.
`timescale 1ns/1ps
`include "dtc_defines.svh"

module dtc_dram_timing import dtc_pkg::*; (
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// processor local bus
	input  wire logic        addr_strobe_n,
	input  wire logic [31:0] cpu_addr,
	input  wire logic        cpu_write,
	input  wire logic        burst_last_n,
	output logic             dram_ready,
	// refresh request and grant
	input  wire logic        refresh_req,
	output logic             refresh_gnt,
	// dram module banks
	output logic      [3:0]  dram_ras_n,
	output logic             dram_cas_n,
	output logic             dram_we_n,
	output logic      [10:0] dram_addr
);

	// ---- register port decode ----
	logic [15:0] cfg;
	logic [1:0]  byte_wr;
	logic        sel_lo;
	logic        sel_hi;
	logic        sel_st;
	logic [7:0]  status;
	logic [7:0]  rdata_d;
	logic [7:0]  rdata_q;

	// address match for each byte; unmapped offsets read as zero
	assign sel_lo  = (reg_addr == `DTC_OFS_CFG_LO);
	assign sel_hi  = (reg_addr == `DTC_OFS_CFG_HI);
	assign sel_st  = (reg_addr == `DTC_OFS_STATUS);
	assign byte_wr = {reg_wr & sel_hi, reg_wr & sel_lo};
	assign rdata_d = sel_lo ? cfg[7:0] :
	                 sel_hi ? cfg[15:8] :
	                 sel_st ? status : 8'h00;

	// read data stands only in the cycle after the read strobe
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= reg_rd ? rdata_d : 8'h00;
		end
	end
	assign reg_rdata = rdata_q;

	dtc_cfg_reg u_cfg (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.byte_wr (byte_wr),
		.wdata   (reg_wdata),
		.cfg     (cfg)
	);

	// ---- live field decode ----
	logic       f_fpm;
	logic       f_dual;
	dtc_depth_e f_depth;
	logic       f_ads_dly;
	logic [1:0] f_rfsh;
	logic [1:0] f_prechg;
	logic [1:0] f_wad;
	logic [1:0] f_wdd;
	logic [1:0] f_rad;
	logic [1:0] f_rdd;

	dtc_field_decode u_dec (
		.cfg           (cfg),
		.fpm_mode      (f_fpm),
		.dual_bank     (f_dual),
		.depth         (f_depth),
		.ads_delay     (f_ads_dly),
		.rfsh_cycles   (f_rfsh),
		.prechg_cycles (f_prechg),
		.wr_addr_wait  (f_wad),
		.wr_data_wait  (f_wdd),
		.rd_addr_wait  (f_rad),
		.rd_data_wait  (f_rdd)
	);

	// ---- request detection ----
	logic        req_now;
	logic        req_dly_q;
	logic [31:0] addr_dly_q;
	logic        wr_dly_q;
	logic        req_use;
	logic [31:0] addr_use;
	logic        wr_use;

	// strobe low with dram region selected starts an access
	assign req_now = ~addr_strobe_n &
	                 (cpu_addr[31:30] == `DTC_DRAM_REGION);

	// one-clock copy of the request, for slow address settling
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			req_dly_q  <= 1'b0;
			addr_dly_q <= 32'h0000_0000;
			wr_dly_q   <= 1'b0;
		end else begin
			req_dly_q  <= req_now;
			addr_dly_q <= cpu_addr;
			wr_dly_q   <= cpu_write;
		end
	end

	// a request that arrives while busy is lost; the processor waits
	// for ready, so it cannot issue another one in the meantime
	assign req_use  = f_ads_dly ? req_dly_q : req_now;
	assign addr_use = f_ads_dly ? addr_dly_q : cpu_addr;
	assign wr_use   = f_ads_dly ? wr_dly_q : cpu_write;

	// ---- address split per depth ----
	// returns {bank[1:0], row[10:0], col[10:0]} for a byte address
	function automatic logic [23:0] split(input dtc_depth_e d,
	                                      input logic       dual,
	                                      input logic [31:0] a);
		logic [1:0]  bk;
		logic [10:0] row;
		logic [10:0] col;
		bk  = 2'h0;
		row = 11'h000;
		col = 11'h000;
		unique case (d)
			DTC_D256K: begin
				col = {2'h0, a[10:2]};
				row = {2'h0, a[19:11]};
				bk  = {a[20], dual & a[21]};
			end
			DTC_D1M: begin
				col = {1'b0, a[11:2]};
				row = {1'b0, a[21:12]};
				bk  = {a[22], dual & a[23]};
			end
			DTC_D4M: begin
				col = a[12:2];
				row = a[23:13];
				bk  = {a[24], dual & a[25]};
			end
			default: begin
				col = 11'h000;
				row = 11'h000;
				bk  = 2'h0;
			end
		endcase
		split = {bk, row, col};
	endfunction : split

	logic [23:0] split_now;
	assign split_now = split(f_depth, f_dual, addr_use);

	// ---- sequencer ----
	dtc_state_e  state_q;
	dtc_state_e  state_d;
	logic [1:0]  cnt_q;
	logic [1:0]  cnt_d;
	logic [1:0]  beat_q;
	logic [1:0]  beat_nx;
	logic        wr_q;
	logic        fpm_q;
	logic [1:0]  dwait_q;
	logic [1:0]  prechg_q;
	logic [1:0]  bank_q;
	logic [10:0] col_q;
	logic [10:0] addr_q;
	logic        start_acc;
	logic        start_rfsh;
	logic        last_beat;
	logic [1:0]  bank_sel;
	logic        ras_on;

	// refresh wins over a processor access in the same cycle
	assign start_rfsh = (state_q == DTC_IDLE) & refresh_req;
	assign start_acc  = (state_q == DTC_IDLE) & ~refresh_req & req_use;
	assign last_beat  = ~burst_last_n;
	// bank 1 of a socket only exists in dual-bank mode
	assign bank_sel   = split_now[23:22];

	// next state and counter
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		unique case (state_q)
			DTC_IDLE: begin
				if (start_rfsh) begin
					state_d = DTC_RFSH;
					cnt_d   = f_rfsh;
				end else if (start_acc) begin
					state_d = DTC_ADDR_WT;
					cnt_d   = wr_use ? f_wad : f_rad;
				end
			end
			DTC_RFSH: begin
				if (cnt_q == 2'h1) begin
					state_d = DTC_PRECHG;
					cnt_d   = prechg_q;
				end else begin
					cnt_d = cnt_q - 2'h1;
				end
			end
			DTC_ADDR_WT: begin
				if (cnt_q == 2'h1) begin
					state_d = DTC_DATA;
				end else begin
					cnt_d = cnt_q - 2'h1;
				end
			end
			DTC_DATA: begin
				if (last_beat) begin
					state_d = DTC_PRECHG;
					cnt_d   = prechg_q;
				end else if (dwait_q != 2'h0) begin
					state_d = DTC_DATA_WT;
					cnt_d   = dwait_q;
				end
			end
			DTC_DATA_WT: begin
				if (cnt_q == 2'h1) begin
					state_d = DTC_DATA;
				end else begin
					cnt_d = cnt_q - 2'h1;
				end
			end
			DTC_PRECHG: begin
				if (cnt_q == 2'h1) begin
					state_d = DTC_IDLE;
				end else begin
					cnt_d = cnt_q - 2'h1;
				end
			end
			default: begin
				state_d = DTC_IDLE;
				cnt_d   = 2'h0;
			end
		endcase
	end

	// state and counter registers
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_q <= DTC_IDLE;
			cnt_q   <= 2'h0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	// fields frozen at the start, so software cannot upset a live access
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			wr_q     <= 1'b0;
			fpm_q    <= 1'b1;
			dwait_q  <= 2'h0;
			prechg_q <= `DTC_PRECHG_LONG;
			bank_q   <= 2'h0;
			col_q    <= 11'h000;
		end else if (start_rfsh) begin
			prechg_q <= f_prechg;
		end else if (start_acc) begin
			wr_q     <= wr_use;
			fpm_q    <= f_fpm;
			dwait_q  <= wr_use ? f_wdd : f_rdd;
			prechg_q <= f_prechg;
			bank_q   <= bank_sel;
			col_q    <= split_now[10:0];
		end
	end

	// burst beat counter steps the column within a four-word burst
	always_ff @(posedge mclk) begin
		if (sys_rst || start_acc) begin
			beat_q <= 2'h0;
		end else if (state_q == DTC_DATA) begin
			beat_q <= beat_q + 2'h1;
		end
	end

	// beat of the next data cycle; leaving a data cycle it has moved on,
	// so zero-wait bursts do not repeat the previous column
	assign beat_nx = (state_q == DTC_DATA) ? beat_q + 2'h1 : beat_q;

	// row on the pins first, then the column of the current beat
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			addr_q <= 11'h000;
		end else if (start_acc) begin
			addr_q <= split_now[21:11];
		end else if (state_d == DTC_DATA || state_d == DTC_DATA_WT) begin
			addr_q <= {col_q[10:2], col_q[1:0] + beat_nx};
		end
	end
	assign dram_addr = addr_q;

	// ---- dram strobes ----
	assign ras_on = (state_q == DTC_RFSH) || (state_q == DTC_ADDR_WT) ||
	                (state_q == DTC_DATA) || (state_q == DTC_DATA_WT);

	// refresh strobes every bank; an access strobes only its own
	for (genvar i = 0; i < 4; i++) begin : g_ras
		assign dram_ras_n[i] = ~(ras_on &&
		                         ((state_q == DTC_RFSH) ||
		                          (bank_q == 2'(i))));
	end

	// edo keeps cas low across read data waits so data stays valid;
	// fast-page parts need cas high to precharge between beats
	assign dram_cas_n = ~((state_q == DTC_DATA) ||
	                      (state_q == DTC_RFSH) ||
	                      (state_q == DTC_DATA_WT && ~fpm_q && ~wr_q));
	assign dram_we_n  = ~(wr_q && (state_q == DTC_ADDR_WT ||
	                               state_q == DTC_DATA ||
	                               state_q == DTC_DATA_WT));

	// ---- processor handshakes ----
	assign dram_ready  = (state_q == DTC_DATA);
	assign refresh_gnt = start_rfsh;

	// status: state, beat, frozen direction and type
	assign status = {fpm_q, wr_q, beat_q, 1'b0, state_q};

endmodule : dtc_dram_timing

// file: dv/dtc_cpu_model.sv
// dtc_cpu_model.sv: processor bus model that issues dram bursts.
// assumes: same clock as the block; go is a one-cycle request.
`timescale 1ns/1ps

module dtc_cpu_model (
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic        go,
	input  wire logic        go_write,
	input  wire logic [2:0]  go_beats,
	input  wire logic        dram_ready,
	output logic             addr_strobe_n,
	output logic      [31:0] cpu_addr,
	output logic             cpu_write,
	output logic             burst_last_n
);
	logic [2:0] beat_q;
	logic [2:0] last_q;
	logic       busy_q;

	// burst end flagged in the data cycle of the final beat
	assign burst_last_n = !(busy_q && beat_q == last_q);

	// address and direction held for the whole burst, since the
	// block may take them one clock after the strobe
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			addr_strobe_n <= 1'b1;
			busy_q        <= 1'b0;
			beat_q        <= 3'h0;
			last_q        <= 3'h0;
			cpu_write     <= 1'b0;
			cpu_addr      <= 32'h0;
		end else if (go) begin
			addr_strobe_n <= 1'b0;
			busy_q        <= 1'b1;
			beat_q        <= 3'h0;
			last_q        <= go_beats - 3'h1;
			cpu_write     <= go_write;
			cpu_addr      <= 32'h0000_1D04; // column differs per depth
		end else begin
			addr_strobe_n <= 1'b1;
			if (dram_ready)
				beat_q <= beat_q + 3'h1;
			if (dram_ready && !burst_last_n)
				busy_q <= 1'b0;
		end
	end
endmodule : dtc_cpu_model

// file: dv/dtc_dram_timing_sva.sv
// dtc_dram_timing_sva.sv: port-level checks of the timing block.
// assumes: bound to dtc_dram_timing; config word shadowed from writes.
`timescale 1ns/1ps

module dtc_dram_timing_sva (
	input wire logic       mclk,
	input wire logic       sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       burst_last_n,
	input wire logic       dram_ready,
	input wire logic       refresh_gnt,
	input wire logic [3:0] dram_ras_n,
	input wire logic       dram_cas_n,
	input wire logic       dram_we_n
);
	logic [15:0] cfg_q;

	// shadow of the word, so no internal probes are needed
	always_ff @(posedge mclk) begin
		if (sys_rst)
			cfg_q <= 16'hFFFF;
		else if (reg_wr && reg_addr == 8'h00)
			cfg_q[7:0] <= reg_wdata;
		else if (reg_wr && reg_addr == 8'h01)
			cfg_q[15:8] <= reg_wdata;
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	a_rd_lo_byte: assert property (
		reg_rd && reg_addr == 8'h00 |=> reg_rdata == $past(cfg_q[7:0]))
		else $error("low byte read mismatch");
	a_rd_hi_byte: assert property (
		reg_rd && reg_addr == 8'h01 |=> reg_rdata == $past(cfg_q[15:8]))
		else $error("high byte read mismatch");
	a_rd_unmapped: assert property (
		reg_rd && reg_addr > 8'h02 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_rdata_rest: assert property (
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	a_rfsh_short: assert property (
		refresh_gnt && !cfg_q[9] |=>
		(dram_ras_n == 4'h0)[*2] ##1 dram_ras_n == 4'hF)
		else $error("short refresh width wrong");
	a_rfsh_long: assert property (
		refresh_gnt && cfg_q[9] |=>
		(dram_ras_n == 4'h0)[*3] ##1 dram_ras_n == 4'hF)
		else $error("long refresh width wrong");
	a_prechg_long: assert property (
		$rose(dram_ras_n == 4'hF) && cfg_q[8] |-> (dram_ras_n == 4'hF)[*3])
		else $error("two clock precharge cut short");
	a_prechg_short: assert property (
		$rose(dram_ras_n == 4'hF) && !cfg_q[8] |-> (dram_ras_n == 4'hF)[*2])
		else $error("one clock precharge cut short");
	a_ready_strobes: assert property (
		dram_ready |-> !dram_cas_n && dram_ras_n != 4'hF)
		else $error("ready without ras and cas");
	a_rd_no_gap: assert property (
		dram_ready && dram_we_n && burst_last_n && cfg_q[3:2] == 2'h0
		|=> dram_ready)
		else $error("zero data wait read gapped");

	// cover: refresh, burst end, a read back
	c_refresh: cover property (refresh_gnt);
	c_burst_end: cover property (dram_ready && !burst_last_n);
	c_read_back: cover property (reg_rd && reg_addr == 8'h01);
endmodule : dtc_dram_timing_sva

bind dtc_dram_timing dtc_dram_timing_sva u_sva (.mclk, .sys_rst,
	.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .burst_last_n,
	.dram_ready, .refresh_gnt, .dram_ras_n, .dram_cas_n, .dram_we_n);

// file: dv/dtc_dram_timing_tb_top.sv
// dtc_dram_timing_tb_top.sv: register and access timing tests.
// assumes: cpu model on the bus side, checker bound to the dut.
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
	$display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end

module dtc_dram_timing_tb_top;
	logic        mclk, sys_rst, reg_wr, reg_rd, go, go_write;
	logic        refresh_req, strobe_n, cpu_write, last_n, ready;
	logic        gnt, cas_n, we_n;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata;
	logic [31:0] cpu_addr;
	logic [3:0]  ras_n;
	logic [10:0] dram_a;
	int          errors, check_count, cyc;
	// {cfg, write, strobe delay, addr waits, data waits}
	localparam logic [21:0] TBL [8] = '{
		{16'hFFFF, 6'b011110}, {16'h0801, 6'b000100},
		{16'h0006, 6'b001001}, {16'h8006, 6'b001001},
		{16'h1009, 6'b000110}, {16'h0000, 6'b100101},
		{16'h00A0, 6'b101010}, {16'h0470, 6'b111101}};

	dtc_dram_timing dut (.mclk(mclk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .addr_strobe_n(strobe_n),
		.cpu_addr(cpu_addr), .cpu_write(cpu_write), .burst_last_n(last_n),
		.dram_ready(ready), .refresh_req(refresh_req), .refresh_gnt(gnt),
		.dram_ras_n(ras_n), .dram_cas_n(cas_n), .dram_we_n(we_n),
		.dram_addr(dram_a));
	dtc_cpu_model cpu (.mclk(mclk), .sys_rst(sys_rst), .go(go),
		.go_write(go_write), .go_beats(3'h2), .dram_ready(ready),
		.addr_strobe_n(strobe_n), .cpu_addr(cpu_addr),
		.cpu_write(cpu_write), .burst_last_n(last_n));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// hang guard, far above the fewer than two hundred cycles needed
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			wrap_up();
		end
	end

	task wrap_up;
		if (errors == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : wrap_up

	// strobe left high; reg_read or bus_idle drops it, a following reg_write keeps it high
	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		reg_rd    <= 1'b0;
		@(posedge mclk);
	endtask : reg_write

	task automatic bus_idle;
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		@(posedge mclk);
	endtask : bus_idle

	// data stand only in the cycle after the strobe
	task automatic reg_read(input logic [7:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		reg_wr   <= 1'b0;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 `CHK(reg_rdata, e)
		@(posedge mclk);
	endtask : reg_read

	// two-beat burst; cycles from go to each ready are measured
	task automatic access(input logic [21:0] e, input logic mid);
		int          n;
		int          last;
		logic        fin;
		logic [10:0] col;
		// column of the model's fixed address for the chosen depth
		col = e[19] ? 11'h741 : (e[18] ? 11'h341 : 11'h141);
		fin = 1'b0;
		reg_write(8'h00, e[13:6]);
		reg_write(8'h01, e[21:14]);
		bus_idle();
		go       <= 1'b1;
		go_write <= e[5];
		@(posedge mclk);
		go   <= 1'b0;
		n    = 1;
		last = 0;
		repeat (40) begin
			@(posedge mclk);
			n++;
			// mid-access rewrite of the read data waits must not
			// reach the running access
			if (mid && n == 4) begin
				reg_addr  <= 8'h00;
				reg_wdata <= 8'hF7;
				reg_wr    <= 1'b1;
			end
			if (mid && n == 5)
				reg_wr <= 1'b0;
			#1;
			if (ready && last == 0) begin
				`CHK(n, 2 + e[4] + e[3:2])
				`CHK(dram_a, col)
				`CHK(ras_n, 4'hE)
				`CHK(we_n, !e[5])
				last = n;
			end else if (ready) begin
				`CHK(n - last, e[1:0] + 1)
				`CHK(dram_a, col + 11'h001)
				fin = 1'b1;
				break;
			end else if (last != 0 && !e[5])
				`CHK(cas_n, e[21])
		end
		`CHK(fin, 1'b1)
		repeat (4) @(posedge mclk);
	endtask : access

	task automatic rfsh(input logic [7:0] hi, input int w);
		int n;
		reg_write(8'h01, hi);
		bus_idle();
		refresh_req <= 1'b1;
		#1 `CHK(gnt, 1'b1)
		@(posedge mclk);
		refresh_req <= 1'b0;
		n = 0;
		// first look falls in the cycle right after the grant edge
		repeat (8) begin
			#1;
			if (ras_n === 4'h0)
				n++;
			@(posedge mclk);
		end
		`CHK(n, w)
	endtask : rfsh

	initial begin
		sys_rst = 1'b1;
		{reg_wr, reg_rd, go, go_write, refresh_req} = '0;
		{reg_addr, reg_wdata} = '0;
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		reg_read(8'h00, 8'hFF);
		reg_read(8'h01, 8'hFF);
		reg_write(8'h00, 8'h5A);
		reg_write(8'h01, 8'hA8);
		reg_read(8'h00, 8'h5A);
		reg_read(8'h01, 8'hA8);
		reg_read(8'h07, 8'h00);
		foreach (TBL[i])
			access(TBL[i], 1'b0);
		access({16'hFFFF, 6'b011110}, 1'b1);
		rfsh(8'hFD, 2);
		rfsh(8'hFE, 3);
		sys_rst <= 1'b1;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		reg_read(8'h01, 8'hFF);
		reg_read(8'h00, 8'hFF);
		wrap_up();
	end
endmodule : dtc_dram_timing_tb_top
